// *** hdl/hlc_regs.sv ***
// haptic loop calibration register bank with drive limiting and calibration
`timescale 1ns/1ps
`default_nettype none
module hlc_regs (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	// register access
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	output logic [7:0]       reg_rdata_out,
	output logic             reg_rvalid_out,
	// calibration
	input  wire logic        cal_done_in,
	input  wire logic [7:0]  cal_impedance_in,
	input  wire logic [7:0]  cal_basis_in,
	// playback engine
	input  wire logic [7:0]  drive_req_in,
	input  wire logic        overdrive_in,
	input  wire logic        braking_in,
	output logic [7:0]       drive_out,
	output logic [8:0]       fb_gain_out,
	output logic [2:0]       brake_ratio_out,
	output logic [1:0]       loop_gain_out,
	output logic [1:0]       amp_gain_out
);
	typedef struct packed {
		logic       rvalid;
		logic [2:0] rd_idx;
		logic [7:0] drive;
		logic [8:0] gain;
		logic [2:0] brk;
		logic [1:0] lg;
		logic [1:0] amp;
	} hlc_st_t;
	hlc_st_t s_r, s_nxt;

	logic [39:0] regs;
	logic [7:0]  rf_rd;
	logic [7:0]  full_scale, od_limit, res_comp_unused, basis, ctrl;
	logic [2:0]  wr_idx, rd_idx;
	logic        wr_hit, rd_hit;
	logic [7:0]  cal_comp;
	logic [1:0]  cal_amp;
	logic [7:0]  limit, clamped, gate;

	////////////////////////////////////////////////////////////////////////
	// address decode: bank sits at five consecutive offsets
	always_comb begin
		wr_hit = reg_addr_in >= hlc_pkg::OFS_FULL_SCALE && reg_addr_in <= hlc_pkg::OFS_LOOP_CTRL;
		wr_idx = 3'(reg_addr_in - hlc_pkg::OFS_FULL_SCALE);
		rd_hit = wr_hit;
		rd_idx = rd_hit ? wr_idx : 3'h7;
	end

	// calibration results; amp gain picked by impedance band
	always_comb begin
		cal_comp = 8'(hlc_pkg::COMP_BASE + {1'b0, cal_impedance_in[7:1]});
		if (cal_impedance_in < hlc_pkg::AMP_THR_LO) begin
			cal_amp = 2'h3;
		end else if (cal_impedance_in < hlc_pkg::AMP_THR_HI) begin
			cal_amp = 2'h2;
		end else begin
			cal_amp = 2'h1;
		end
	end

	hlc_reg_file u_rf (
		.mclk_in      (mclk_in),
		.rst_n_in     (rst_n_in),
		.wr_en_in     (reg_wr_in && wr_hit),
		.wr_idx_in    (wr_idx),
		.wr_data_in   (reg_wdata_in),
		.rd_idx_in    (rd_idx),
		.cal_wr_in    (cal_done_in),
		.cal_comp_in  (cal_comp),
		.cal_basis_in (cal_basis_in),
		.cal_amp_in   (cal_amp),
		.rd_data_out  (rf_rd),
		.regs_out     (regs)
	);

	always_comb begin
		full_scale      = regs[7:0];
		od_limit        = regs[15:8];
		res_comp_unused = regs[23:16];
		basis           = regs[31:24];
		ctrl            = regs[39:32];
	end

	////////////////////////////////////////////////////////////////////////
	// drive path: limit, then noise gate
	always_comb begin
		// rated level caps normal drive; clamp caps overdrive and braking
		limit   = (overdrive_in || braking_in) ? od_limit : full_scale;
		clamped = (drive_req_in > limit) ? limit : drive_req_in;
		gate    = ctrl[hlc_pkg::NG_BIT] ? hlc_pkg::NG_HIGH : hlc_pkg::NG_LOW;
		s_nxt        = s_r;
		s_nxt.drive  = (clamped < gate) ? 8'h00 : clamped;
		// feedback gain is basis plus half basis whether braking or not; ratio field applied downstream
		s_nxt.gain   = {1'b0, basis} + {2'b00, basis[7:1]};
		s_nxt.brk    = ctrl[hlc_pkg::BRK_LSB +: 3];
		s_nxt.lg     = ctrl[hlc_pkg::GAIN_LSB +: 2];
		s_nxt.amp    = ctrl[hlc_pkg::AMP_LSB +: 2];
		s_nxt.rvalid = reg_rd_in;
		s_nxt.rd_idx = rd_idx;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// read data registered inside the file, valid one cycle after request
	assign reg_rdata_out   = rf_rd;
	assign reg_rvalid_out  = s_r.rvalid;
	assign drive_out       = s_r.drive;
	assign fb_gain_out     = s_r.gain;
	assign brake_ratio_out = s_r.brk;
	assign loop_gain_out   = s_r.lg;
	assign amp_gain_out    = s_r.amp;
endmodule
`default_nettype wire

// *** pkg/hlc_pkg.sv ***
// package: register map, reset values and field layout of the haptic loop calibration bank
`default_nettype none
package hlc_pkg;
	// register offsets
	localparam logic [7:0] OFS_FULL_SCALE  = 8'h1F;
	localparam logic [7:0] OFS_OD_LIMIT    = 8'h20;
	localparam logic [7:0] OFS_RES_COMP    = 8'h21;
	localparam logic [7:0] OFS_FB_BASIS    = 8'h22;
	localparam logic [7:0] OFS_LOOP_CTRL   = 8'h23;
	localparam int         NUM_REGS        = 5;
	// reset values
	localparam logic [7:0] RST_FULL_SCALE  = 8'h3F;
	localparam logic [7:0] RST_OD_LIMIT    = 8'hFF;
	localparam logic [7:0] RST_RES_COMP    = 8'h0D;
	localparam logic [7:0] RST_FB_BASIS    = 8'h6D;
	localparam logic [7:0] RST_LOOP_CTRL   = 8'h36;
	// loop control fields
	localparam int         NG_BIT          = 7;
	localparam int         BRK_LSB         = 4;
	localparam int         GAIN_LSB        = 2;
	localparam int         AMP_LSB         = 0;
	// noise gate thresholds in supply units of 1/256: 4 % and 8 %
	localparam logic [7:0] NG_LOW          = 8'h0A;
	localparam logic [7:0] NG_HIGH         = 8'h14;
	// calibration: impedance code to compensation, amp gain from impedance
	localparam logic [7:0] COMP_BASE       = 8'h0D;
	localparam logic [7:0] AMP_THR_LO      = 8'h40;
	localparam logic [7:0] AMP_THR_HI      = 8'hA0;
endpackage
`default_nettype wire

// *** hdl/hlc_reg_file.sv ***
// small register file holding the five bank bytes with registered read data
`timescale 1ns/1ps
`default_nettype none
module hlc_reg_file (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	// host port
	input  wire logic        wr_en_in,
	input  wire logic [2:0]  wr_idx_in,
	input  wire logic [7:0]  wr_data_in,
	input  wire logic [2:0]  rd_idx_in,
	// calibration result port
	input  wire logic        cal_wr_in,
	input  wire logic [7:0]  cal_comp_in,
	input  wire logic [7:0]  cal_basis_in,
	input  wire logic [1:0]  cal_amp_in,
	// outputs
	output logic [7:0]       rd_data_out,
	output logic [39:0]      regs_out
);
	typedef struct packed {
		logic [4:0][7:0] mem;
		logic [7:0]      rd;
	} hlc_rf_t;
	hlc_rf_t s_r, s_nxt;
	localparam logic [39:0] RST_ALL = {hlc_pkg::RST_LOOP_CTRL, hlc_pkg::RST_FB_BASIS,
		hlc_pkg::RST_RES_COMP, hlc_pkg::RST_OD_LIMIT, hlc_pkg::RST_FULL_SCALE};

	always_comb begin
		s_nxt = s_r;
		if (wr_en_in && wr_idx_in < 3'(hlc_pkg::NUM_REGS)) begin
			s_nxt.mem[wr_idx_in] = wr_data_in;
		end
		// calibration results land after a host write in the same cycle
		if (cal_wr_in) begin
			s_nxt.mem[2] = cal_comp_in;
			s_nxt.mem[3] = cal_basis_in;
			s_nxt.mem[4][1:0] = cal_amp_in;
		end
		s_nxt.rd = (rd_idx_in < 3'(hlc_pkg::NUM_REGS)) ? s_r.mem[rd_idx_in] : 8'h00;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			s_r <= {RST_ALL, 8'h00};
		end else begin
			s_r <= s_nxt;
		end
	end
	assign rd_data_out = s_r.rd;
	assign regs_out    = s_r.mem;
endmodule
`default_nettype wire

// *** verification/hlc_regs_props.sv ***
// assertions on the calibration register bank ports
`timescale 1ns/1ps
`default_nettype none
module hlc_regs_props (
	input wire logic       mclk_in,
	input wire logic       rst_n_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       reg_rvalid_out,
	input wire logic       cal_done_in,
	input wire logic [7:0] cal_impedance_in,
	input wire logic [7:0] drive_req_in,
	input wire logic [7:0] drive_out,
	input wire logic [8:0] fb_gain_out,
	input wire logic [2:0] brake_ratio_out,
	input wire logic [1:0] loop_gain_out,
	input wire logic [1:0] amp_gain_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	// reset in the term keeps the release edge out of the hold check
	sequence quiet_s;
		rst_n_in && !reg_wr_in && !cal_done_in;
	endsequence
	sequence ctrl_wr_s;
		reg_wr_in && reg_addr_in == 8'h23 && !cal_done_in;
	endsequence
	sequence cal_low_s;
		cal_done_in && cal_impedance_in < 8'h40 ##1 !reg_wr_in;
	endsequence
	read_ack_a: assert property (reg_rd_in |=> reg_rvalid_out) else $error("read not acknowledged");
	reset_fields_a: assert property ($rose(rst_n_in) |=> {fb_gain_out, brake_ratio_out, loop_gain_out,
		amp_gain_out} == 16'h51B6) else $error("reset fields wrong");
	ctrl_write_a: assert property (ctrl_wr_s |-> ##2 {1'b0, brake_ratio_out, loop_gain_out, 2'h0}
		== ($past(reg_wdata_in, 2) & 8'h7C)) else $error("control fields not updated");
	amp_cal_a: assert property (cal_low_s |=> amp_gain_out == 2'h3) else $error("amp gain not calibrated");
	drive_cap_a: assert property (rst_n_in |=> drive_out <= $past(drive_req_in)) else $error("drive above request");
	noise_gate_a: assert property (drive_req_in < 8'h0A |=> drive_out == 8'h00) else $error("gate open");
	unmapped_rd_a: assert property (reg_rd_in && (reg_addr_in < 8'h1F || reg_addr_in > 8'h23)
		|=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
	field_hold_a: assert property (quiet_s [*3] |=> $stable({fb_gain_out, brake_ratio_out, loop_gain_out,
		amp_gain_out})) else $error("fields moved without cause");
endmodule
bind hlc_regs hlc_regs_props i_props (.mclk_in, .rst_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
	.reg_rdata_out, .reg_rvalid_out, .cal_done_in, .cal_impedance_in, .drive_req_in, .drive_out, .fb_gain_out,
	.brake_ratio_out, .loop_gain_out, .amp_gain_out);
`default_nettype wire

// *** verification/hlc_host.sv ***
// host model issuing single byte register accesses
`timescale 1ns/1ps
`default_nettype none
module hlc_host (
	input  wire logic       mclk_in,
	output logic            wr_out,
	output logic            rd_out,
	output logic [7:0]      addr_out,
	output logic [7:0]      wdata_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in) #1;
		wr_out = 1'b1;
		addr_out = a;
		wdata_out = d;
		@(posedge mclk_in) #1;
		wr_out = 1'b0;
		// stale data inverted so a late capture shows
		wdata_out = ~d;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk_in) #1;
		rd_out = 1'b1;
		addr_out = a;
		@(posedge mclk_in) #1;
		rd_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// *** verification/test_haptic_loop_calibration_regs.sv ***
// self-checking bench for the calibration register bank
`timescale 1ns/1ps
`default_nettype none
module test_haptic_loop_calibration_regs;
	logic       clk, rst_n, wr, rd, cal, od, br, rv;
	logic [7:0] addr, wd, imp, bas, req, rdat, drv;
	logic [8:0] fbg;
	logic [2:0] brk;
	logic [1:0] lg, ag;
	int         bad_count, checks;
	hlc_regs i_dut (.mclk_in(clk), .rst_n_in(rst_n), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_rdata_out(rdat), .reg_rvalid_out(rv), .cal_done_in(cal), .cal_impedance_in(imp),
		.cal_basis_in(bas), .drive_req_in(req), .overdrive_in(od), .braking_in(br), .drive_out(drv),
		.fb_gain_out(fbg), .brake_ratio_out(brk), .loop_gain_out(lg), .amp_gain_out(ag));
	hlc_host i_host (.mclk_in(clk), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		i_host.rd(a);
		cmp({rv, rdat}, {1'b1, exp});
	endtask
	task automatic dr(input logic [7:0] r, input logic o, input logic b, input logic [7:0] exp);
		@(posedge clk) #1;
		{req, od, br} = {r, o, b};
		@(posedge clk) #1;
		cmp(drv, exp);
	endtask
	task automatic cl(input logic [7:0] i, input logic [7:0] b, input logic [1:0] a, input logic [7:0] c);
		@(posedge clk) #1;
		{cal, imp, bas} = {1'b1, i, b};
		@(posedge clk) #1;
		cal = 1'b0;
		repeat (2) @(posedge clk);
		#1 cmp({ag, fbg}, {a, 1'b0, b} + b[7:1]);
		rdc(8'h21, c);
		rdc(8'h22, b);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		{rst_n, cal, od, br, imp, bas, req, bad_count, checks} = '0;
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		rdc(8'h1F, 8'h3F);
		rdc(8'h20, hlc_pkg::RST_OD_LIMIT);
		rdc(8'h21, 8'h0D);
		rdc(8'h22, 8'h6D);
		rdc(8'h23, 8'h36);
		cmp({brk, lg, ag}, 7'h36);
		$display("reset test done");
		for (int i = 0; i < 5; i++) i_host.wr(8'h1F + i[7:0], 8'h5A + 8'h11 * i[7:0]);
		i_host.wr(8'h24, 8'h77);
		for (int i = 0; i < 5; i++) rdc(8'h1F + i[7:0], 8'h5A + 8'h11 * i[7:0]);
		rdc(8'h24, 8'h00);
		rdc(8'h1E, 8'h00);
		cmp({brk, lg, ag}, 7'h1E);
		$display("access test done");
		i_host.wr(8'h1F, 8'h40);
		i_host.wr(8'h20, 8'h80);
		i_host.wr(8'h23, 8'h36);
		dr(8'h60, 1'b0, 1'b0, 8'h40);
		dr(8'h60, 1'b1, 1'b0, 8'h60);
		dr(8'hF0, 1'b0, 1'b1, 8'h80);
		dr(8'h0B, 1'b0, 1'b0, 8'h0B);
		dr(8'h09, 1'b0, 1'b0, 8'h00);
		i_host.wr(8'h23, 8'hB6);
		dr(8'h13, 1'b0, 1'b0, 8'h00);
		dr(8'h14, 1'b0, 1'b0, 8'h14);
		$display("drive test done");
		i_host.wr(8'h1F, 8'h50);
		i_host.wr(8'h23, 8'h36);
		cl(8'h20, 8'h44, 2'h3, 8'h1D);
		i_host.wr(8'h1F, 8'h60);
		cl(8'h80, 8'h30, 2'h2, 8'h4D);
		cl(8'hC0, 8'h10, 2'h1, 8'h6D);
		$display("calibration test done");
		test_done();
	end
endmodule
`default_nettype wire
